// [pio_pkg.sv]
/*
 * Shared constants of the parallel I/O tape interface: register offsets,
 * control and status bit positions, I/O line layout and transfer timing.
 * Assumes a single 200 MHz system clock; times are in nanoseconds.
 */
`default_nettype none

package pio_pkg;

   // Register byte offsets in the I/O space
   localparam logic [6:0] OFS_SPARE     = 7'h00;
   localparam logic [6:0] OFS_CAPTURE   = 7'h02;
   localparam logic [6:0] OFS_ALT_LOW   = 7'h04;
   localparam logic [6:0] OFS_BASE      = 7'h06;
   localparam logic [6:0] OFS_MASK0     = 7'h08;
   localparam logic [6:0] OFS_MASK1     = 7'h0A;
   localparam logic [6:0] OFS_MASK2     = 7'h0C;
   localparam logic [6:0] OFS_VECTOR    = 7'h0E;
   localparam logic [6:0] OFS_MODE0     = 7'h10;
   localparam logic [6:0] OFS_MODE1     = 7'h12;
   localparam logic [6:0] OFS_MODE2     = 7'h14;
   localparam logic [6:0] OFS_ALT_MID   = 7'h16;
   localparam logic [6:0] OFS_INVERT0   = 7'h18;
   localparam logic [6:0] OFS_INVERT1   = 7'h1A;
   localparam logic [6:0] OFS_INVERT2   = 7'h1C;
   localparam logic [6:0] OFS_STATUS    = 7'h1E;
   localparam logic [6:0] OFS_HELD0     = 7'h20;
   localparam logic [6:0] OFS_HELD1     = 7'h22;
   localparam logic [6:0] OFS_HELD2     = 7'h24;
   localparam logic [6:0] OFS_ALT_HIGH  = 7'h26;
   localparam logic [6:0] OFS_RAW0      = 7'h28;
   localparam logic [6:0] OFS_RAW1      = 7'h2A;
   localparam logic [6:0] OFS_RAW2      = 7'h2C;

   // Base control bits
   localparam int BASE_IRQ_EN   = 1;
   localparam int BASE_FORCE    = 2;
   localparam int BASE_WR_ODD   = 4;
   localparam int BASE_RD_ODD   = 5;

   // Status bits
   localparam int STAT_BUSY     = 0;
   localparam int STAT_PAR_ERR  = 1;

   // I/O line layout
   localparam int LINES         = 48;
   localparam int ADDR_BITS     = 22;
   localparam int DATA_LO       = 22;
   localparam int DATA_BITS     = 16;
   localparam int PARITY_LINE   = 38;
   localparam int XFER_N_LINE   = 39;
   localparam int ASTB_N_LINE   = 40;
   localparam int DSTB_LINE     = 41;
   localparam int DIR_LINE      = 42;
   localparam int STAT_LO       = 43;
   localparam int GROUP         = 16;
   localparam int GROUPS        = 3;

   // Reset values
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [16:0] DATA_RELEASE = 17'h1FFFF;

   // Bus answer: one wait state
   localparam logic [1:0] BUS_IDLE  = 2'h0;
   localparam logic [1:0] BUS_WAIT  = 2'h1;
   localparam logic [1:0] BUS_ACK   = 2'h2;
   localparam logic [1:0] BUS_DONE  = 2'h3;

   // Transfer timing (ns) and derived cycle counts at the system clock
   localparam int CLK_MHZ       = 200;
   localparam int T_SETUP_NS    = 500;
   localparam int T_RD_DATA_NS  = 1000;
   localparam int T_WR_DATA_NS  = 2000;
   localparam int T_RECOVER_NS  = 250;
   localparam int SETUP_CYC     = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_DATA_CYC   = (T_RD_DATA_NS * CLK_MHZ + 999) / 1000;
   localparam int WR_DATA_CYC   = (T_WR_DATA_NS * CLK_MHZ + 999) / 1000;
   localparam int RECOVER_CYC   = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_SETUP,
      SEQ_DATA,
      SEQ_RECOVER,
      SEQ_STORE,
      SEQ_DRAIN
   } pio_seq_t;

endpackage : pio_pkg

`default_nettype wire

// [pio_pair_buffer.sv]
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module pio_pair_buffer #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);

   logic [WIDTH-1:0] mem_q [2];
   logic             wrPtr_q;
   logic             rdPtr_q;
   logic [1:0]       count_q;
   logic             push;
   logic             pop;

   assign inReady  = (count_q != 2'h2);
   assign outValid = (count_q != 2'h0);
   assign outData  = mem_q[rdPtr_q];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem_q[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wrPtr_q <= 1'b0;
         rdPtr_q <= 1'b0;
         count_q <= 2'h0;
      end
      else
      begin
         if (push)
            wrPtr_q <= ~wrPtr_q;
         if (pop)
            rdPtr_q <= ~rdPtr_q;
         if (push && !pop)
            count_q <= count_q + 2'h1;
         else if (pop && !push)
            count_q <= count_q - 2'h1;
      end
   end

endmodule : pio_pair_buffer

`default_nettype wire

// [pio_tape_top.sv]
/*
 * Parallel I/O tape interface: IP bus slave with one wait state, tape
 * transfer sequencer on 48 I/O lines, and per-line input hold filter
 * with a maskable interrupt.
 * Assumes all bus and pin inputs are synchronous to sys_clk; open-drain
 * and tri-state resolution of the I/O lines is done outside.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Lines 21..0 always drive the captured transfer address.
// - Seventeen data and parity lines released (all ones) outside write cycles.
// - Four control outputs always driven: active, address strobe, data strobe, direction.
// - A memory-space access while the sequencer is idle starts a transfer; busy holds until data stored.
// - Host write is answered after one wait state; busy clears at transfer end.
// - Host memory read answers after one wait state with invalid data.
// - Strobe phases timed by sequencer constants; write cycle longer than read.
// - Sequencer delays are parameters, changeable without restructuring.
// - All 48 lines sampled back, readable raw and through the hold path.
// - Per-channel inversion then enable gate the filtered capture.
// - Edge mode sets hold on rising edge; level mode whenever high.
// - Pins registered, registered again after gating, then per-channel hold latch.
// - Hold latches cleared per sixteen-channel group by its read; no event lost.
// - Pulses of two reference clocks are caught.
// - All registers and filter logic run on the one bus clock.
// - OR of held bits drives the interrupt line when master enable set.
// - Interrupt drops when held data read or master enable cleared.
// - Per-channel mask and writable vector, readable also in acknowledge space.
// - Identity bytes read-only, one per word; registers are 16-bit words.
// - Every configuration register reads back its last written value.
// - Odd/even parity selects; write parity generated, read mismatch flagged.
// - Tape read data captured, then moved to a second holding register.
// - Base bit 1 is master enable, bit 2 forces interrupt under that enable.
// - Mode bit one means edge capture; invert bit one inverts the channel.
module pio_tape_top #(
   parameter int SETUP_CYC   = pio_pkg::SETUP_CYC,
   parameter int RD_DATA_CYC = pio_pkg::RD_DATA_CYC,
   parameter int WR_DATA_CYC = pio_pkg::WR_DATA_CYC,
   parameter int RECOVER_CYC = pio_pkg::RECOVER_CYC,
   parameter logic [7:0] ID_BYTE0 = 8'h5A,  // Arbitrary identity value
   parameter logic [7:0] ID_BYTE1 = 8'h11,  // Arbitrary identity value
   parameter logic [7:0] ID_BYTE2 = 8'h22,  // Arbitrary identity value
   parameter logic [7:0] ID_BYTE3 = 8'h33   // Arbitrary identity value
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // IP bus
   input  wire logic        ioSel_n,
   input  wire logic        memSel_n,
   input  wire logic        idSel_n,
   input  wire logic        intSel_n,
   input  wire logic        rdWr,
   input  wire logic [5:0]  ipAddr,
   input  wire logic [21:0] memAddr,
   input  wire logic [15:0] ipDataIn,
   output logic      [15:0] ipDataOut,
   output logic             ipDataOe,
   output logic             ack_n,
   output logic             intReq0_n,
   // I/O lines
   input  wire logic [47:0] ioIn,
   output logic      [47:0] ioOut,
   output logic      [47:0] ioOe
);

   localparam int CW = 16;

   // Bus slave
   logic [1:0]  busCnt_q;
   logic        take;
   logic [6:0]  ofs;
   logic [15:0] rdData;
   logic [15:0] dataOut_q;
   logic        anySel;

   // Registers
   logic [15:0] spare_q;
   logic [15:0] base_q;
   logic [15:0] vector_q;
   logic [15:0] mask_q   [3];
   logic [15:0] mode_q   [3];
   logic [15:0] invert_q [3];
   logic [15:0] alt_q    [3];
   logic [15:0] capture_q;

   // Filter
   logic [47:0] pin_q;
   logic [47:0] cond_q;
   logic [47:0] condPrev_q;
   logic [47:0] hold_q;
   logic [47:0] setHold;
   logic [47:0] clrHold;
   logic [47:0] maskAll;
   logic [47:0] modeAll;
   logic [47:0] invAll;
   logic        irq;

   // Sequencer
   pio_pkg::pio_seq_t state_q;
   logic [15:0] waitCnt_q;
   logic [21:0] xferAddr_q;
   logic        xferRead_q;
   logic [15:0] wrWord_q;
   logic        wrParity_q;
   logic [15:0] tapeWord_q;
   logic        parErr_q;
   logic        busy;
   logic        bufInReady;
   logic        bufOutValid;
   logic [15:0] bufOutData;
   logic        captureRead;

   assign anySel = !ioSel_n || !memSel_n || !idSel_n || !intSel_n;
   assign take   = (busCnt_q == pio_pkg::BUS_WAIT);
   assign ofs    = {ipAddr, 1'b0};

   // One wait state: select seen, wait, then acknowledge
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         busCnt_q <= pio_pkg::BUS_IDLE;
      else
         case (busCnt_q)
            pio_pkg::BUS_IDLE: if (anySel) busCnt_q <= pio_pkg::BUS_WAIT;
            pio_pkg::BUS_WAIT: busCnt_q <= pio_pkg::BUS_ACK;
            pio_pkg::BUS_ACK:  busCnt_q <= pio_pkg::BUS_DONE;
            pio_pkg::BUS_DONE: if (!anySel) busCnt_q <= pio_pkg::BUS_IDLE;
            default:           busCnt_q <= pio_pkg::BUS_IDLE;
         endcase
   end

   assign ack_n     = !(busCnt_q == pio_pkg::BUS_ACK);
   assign ipDataOe  = (busCnt_q == pio_pkg::BUS_ACK) && rdWr;
   assign ipDataOut = dataOut_q;

   assign maskAll = {mask_q[2], mask_q[1], mask_q[0]};
   assign modeAll = {mode_q[2], mode_q[1], mode_q[0]};
   assign invAll  = {invert_q[2], invert_q[1], invert_q[0]};

   // Read multiplexer
   always_comb
   begin
      rdData = pio_pkg::REG_RESET;
      if (!idSel_n)
         case (ipAddr[1:0])
            2'h0:    rdData = {8'h00, ID_BYTE0};
            2'h1:    rdData = {8'h00, ID_BYTE1};
            2'h2:    rdData = {8'h00, ID_BYTE2};
            default: rdData = {8'h00, ID_BYTE3};
         endcase
      else if (!intSel_n)
         rdData = vector_q;
      else if (!ioSel_n)
         case (ofs)
            pio_pkg::OFS_SPARE:    rdData = spare_q;
            pio_pkg::OFS_CAPTURE:  rdData = capture_q;
            pio_pkg::OFS_ALT_LOW:  rdData = alt_q[0];
            pio_pkg::OFS_BASE:     rdData = base_q;
            pio_pkg::OFS_MASK0:    rdData = mask_q[0];
            pio_pkg::OFS_MASK1:    rdData = mask_q[1];
            pio_pkg::OFS_MASK2:    rdData = mask_q[2];
            pio_pkg::OFS_VECTOR:   rdData = vector_q;
            pio_pkg::OFS_MODE0:    rdData = mode_q[0];
            pio_pkg::OFS_MODE1:    rdData = mode_q[1];
            pio_pkg::OFS_MODE2:    rdData = mode_q[2];
            pio_pkg::OFS_ALT_MID:  rdData = alt_q[1];
            pio_pkg::OFS_INVERT0:  rdData = invert_q[0];
            pio_pkg::OFS_INVERT1:  rdData = invert_q[1];
            pio_pkg::OFS_INVERT2:  rdData = invert_q[2];
            pio_pkg::OFS_STATUS:   rdData = {pin_q[47:pio_pkg::STAT_LO], 9'h000,
                                             parErr_q, busy};
            pio_pkg::OFS_HELD0:    rdData = hold_q[15:0];
            pio_pkg::OFS_HELD1:    rdData = hold_q[31:16];
            pio_pkg::OFS_HELD2:    rdData = hold_q[47:32];
            pio_pkg::OFS_ALT_HIGH: rdData = alt_q[2];
            pio_pkg::OFS_RAW0:     rdData = pin_q[15:0];
            pio_pkg::OFS_RAW1:     rdData = pin_q[31:16];
            pio_pkg::OFS_RAW2:     rdData = pin_q[47:32];
            default:               rdData = pio_pkg::REG_RESET;
         endcase
   end

   // Memory-space reads load zero here from the read multiplexer; software ignores it
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         dataOut_q <= pio_pkg::REG_RESET;
      else if (take && rdWr)
         dataOut_q <= rdData;
   end

   // Register writes
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         spare_q  <= pio_pkg::REG_RESET;
         base_q   <= pio_pkg::REG_RESET;
         vector_q <= pio_pkg::REG_RESET;
         for (int i = 0; i < pio_pkg::GROUPS; i++)
         begin
            mask_q[i]   <= pio_pkg::REG_RESET;
            mode_q[i]   <= pio_pkg::REG_RESET;
            invert_q[i] <= pio_pkg::REG_RESET;
            alt_q[i]    <= pio_pkg::REG_RESET;
         end
      end
      else if (take && !rdWr && !ioSel_n)
         case (ofs)
            pio_pkg::OFS_SPARE:    spare_q     <= ipDataIn;
            pio_pkg::OFS_ALT_LOW:  alt_q[0]    <= ipDataIn;
            pio_pkg::OFS_BASE:     base_q      <= ipDataIn;
            pio_pkg::OFS_MASK0:    mask_q[0]   <= ipDataIn;
            pio_pkg::OFS_MASK1:    mask_q[1]   <= ipDataIn;
            pio_pkg::OFS_MASK2:    mask_q[2]   <= ipDataIn;
            pio_pkg::OFS_VECTOR:   vector_q    <= ipDataIn;
            pio_pkg::OFS_MODE0:    mode_q[0]   <= ipDataIn;
            pio_pkg::OFS_MODE1:    mode_q[1]   <= ipDataIn;
            pio_pkg::OFS_MODE2:    mode_q[2]   <= ipDataIn;
            pio_pkg::OFS_ALT_MID:  alt_q[1]    <= ipDataIn;
            pio_pkg::OFS_INVERT0:  invert_q[0] <= ipDataIn;
            pio_pkg::OFS_INVERT1:  invert_q[1] <= ipDataIn;
            pio_pkg::OFS_INVERT2:  invert_q[2] <= ipDataIn;
            pio_pkg::OFS_ALT_HIGH: alt_q[2]    <= ipDataIn;
            default:               ;
         endcase
   end

   // Input filter: pin register, gated register, hold latch
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pin_q      <= '0;
         cond_q     <= '0;
         condPrev_q <= '0;
      end
      else
      begin
         pin_q      <= ioIn;
         cond_q     <= (pin_q ^ invAll) & maskAll;
         condPrev_q <= cond_q;
      end
   end

   // Edge mode looks one stage back so a two-clock pulse still shows a rise
   assign setHold = cond_q & (~modeAll | ~condPrev_q);

   always_comb
   begin
      clrHold = '0;
      if (take && rdWr && !ioSel_n)
         case (ofs)
            pio_pkg::OFS_HELD0: clrHold[15:0]  = '1;
            pio_pkg::OFS_HELD1: clrHold[31:16] = '1;
            pio_pkg::OFS_HELD2: clrHold[47:32] = '1;
            default:            clrHold = '0;
         endcase
   end

   // A new event in the clearing cycle survives the clear
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         hold_q <= '0;
      else
         hold_q <= (hold_q & ~clrHold) | setHold;
   end

   assign irq = base_q[pio_pkg::BASE_IRQ_EN]
                && ((|hold_q) || base_q[pio_pkg::BASE_FORCE]);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         intReq0_n <= 1'b1;
      else
         intReq0_n <= !irq;
   end

   // Transfer sequencer
   assign busy = (state_q != pio_pkg::SEQ_IDLE);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_q    <= pio_pkg::SEQ_IDLE;
         waitCnt_q  <= '0;
         xferAddr_q <= '0;
         xferRead_q <= 1'b1;
         wrWord_q   <= '1;
         wrParity_q <= 1'b1;
      end
      else
         case (state_q)
            pio_pkg::SEQ_IDLE:
               if (take && !memSel_n)
               begin
                  state_q    <= pio_pkg::SEQ_SETUP;
                  xferAddr_q <= memAddr;
                  xferRead_q <= rdWr;
                  wrWord_q   <= ipDataIn;
                  wrParity_q <= (^ipDataIn) ^ base_q[pio_pkg::BASE_WR_ODD];
                  waitCnt_q  <= CW'(SETUP_CYC - 1);
               end
            pio_pkg::SEQ_SETUP:
               if (waitCnt_q == '0)
               begin
                  state_q   <= pio_pkg::SEQ_DATA;
                  waitCnt_q <= xferRead_q ? CW'(RD_DATA_CYC - 1)
                                          : CW'(WR_DATA_CYC - 1);
               end
               else
                  waitCnt_q <= waitCnt_q - 16'h0001;
            pio_pkg::SEQ_DATA:
               if (waitCnt_q == '0)
               begin
                  state_q   <= xferRead_q ? pio_pkg::SEQ_STORE
                                          : pio_pkg::SEQ_RECOVER;
                  waitCnt_q <= CW'(RECOVER_CYC - 1);
               end
               else
                  waitCnt_q <= waitCnt_q - 16'h0001;
            pio_pkg::SEQ_RECOVER:
               if (waitCnt_q == '0)
                  state_q <= pio_pkg::SEQ_IDLE;
               else
                  waitCnt_q <= waitCnt_q - 16'h0001;
            pio_pkg::SEQ_STORE:
               if (bufInReady)
                  state_q <= pio_pkg::SEQ_DRAIN;
            pio_pkg::SEQ_DRAIN:
               if (!bufOutValid)
                  state_q <= pio_pkg::SEQ_IDLE;
            default:
               state_q <= pio_pkg::SEQ_IDLE;
         endcase
   end

   // First capture of tape data at the end of the read strobe
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         tapeWord_q <= '0;
         parErr_q   <= 1'b0;
      end
      else if (state_q == pio_pkg::SEQ_DATA && xferRead_q && waitCnt_q == '0)
      begin
         tapeWord_q <= pin_q[pio_pkg::DATA_LO +: pio_pkg::DATA_BITS];
         parErr_q   <= pin_q[pio_pkg::PARITY_LINE]
                       != ((^pin_q[pio_pkg::DATA_LO +: pio_pkg::DATA_BITS])
                           ^ base_q[pio_pkg::BASE_RD_ODD]);
      end
   end

   // Host read of the holding register stalls the buffer for that cycle
   assign captureRead = take && rdWr && !ioSel_n && (ofs == pio_pkg::OFS_CAPTURE);

   pio_pair_buffer #(
      .WIDTH    (pio_pkg::DATA_BITS)
   ) readBuffer (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .inValid  (state_q == pio_pkg::SEQ_STORE),
      .inReady  (bufInReady),
      .inData   (tapeWord_q),
      .outValid (bufOutValid),
      .outReady (!captureRead),
      .outData  (bufOutData)
   );

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         capture_q <= pio_pkg::REG_RESET;
      else if (bufOutValid && !captureRead)
         capture_q <= bufOutData;
   end

   // I/O line drive
   always_comb
   begin
      logic wrDrive;
      logic [16:0] odWord;
      wrDrive = (state_q == pio_pkg::SEQ_DATA) && !xferRead_q;
      odWord  = wrDrive ? {wrParity_q, wrWord_q} : pio_pkg::DATA_RELEASE;
      ioOut   = '0;
      ioOe    = '0;
      ioOut[pio_pkg::ADDR_BITS-1:0] = xferAddr_q;
      ioOe[pio_pkg::ADDR_BITS-1:0]  = '1;
      // Open drain: pull low only where the word holds a zero
      ioOe[pio_pkg::DATA_LO +: pio_pkg::DATA_BITS + 1] = ~odWord;
      ioOut[pio_pkg::XFER_N_LINE]   = !busy || state_q == pio_pkg::SEQ_STORE
                                      || state_q == pio_pkg::SEQ_DRAIN;
      ioOut[pio_pkg::ASTB_N_LINE]   = !(state_q == pio_pkg::SEQ_SETUP
                                        || state_q == pio_pkg::SEQ_DATA);
      ioOut[pio_pkg::DSTB_LINE]     = (state_q == pio_pkg::SEQ_DATA);
      ioOut[pio_pkg::DIR_LINE]      = xferRead_q;
      ioOe[pio_pkg::XFER_N_LINE]    = 1'b1;
      ioOe[pio_pkg::ASTB_N_LINE]    = 1'b1;
      ioOe[pio_pkg::DSTB_LINE]      = 1'b1;
      ioOe[pio_pkg::DIR_LINE]       = 1'b1;
   end

endmodule : pio_tape_top

`default_nettype wire

// [pio_tape_checker.sv]
/* Port checker for pio_tape_top: bus answer timing and tape line use.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module pio_tape_checker #(
   parameter int RD_DATA_CYC = 4,
   parameter int WR_DATA_CYC = 8
) (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        ioSel_n,
   input wire logic        memSel_n,
   input wire logic        rdWr,
   input wire logic [21:0] memAddr,
   input wire logic        ipDataOe,
   input wire logic        ack_n,
   input wire logic [47:0] ioOut,
   input wire logic [47:0] ioOe
);
   int strobeCnt_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Length of the data strobe, checked when it drops
   always_ff @(posedge sys_clk)
      strobeCnt_q <= (rst || !ioOut[41]) ? 0 : strobeCnt_q + 1;
   property p_ackLat;
      $fell(ioSel_n) || $fell(memSel_n) |-> ack_n ##1 ack_n ##1 !ack_n; endproperty
   a_ackLat: assert property (p_ackLat) else $error("ack latency wrong");
   property p_rdOe; ipDataOe |-> !ack_n && rdWr; endproperty
   a_rdOe: assert property (p_rdOe) else $error("data enable outside read ack");
   property p_addrOe; ioOe[21:0] == 22'h3FFFFF; endproperty
   a_addrOe: assert property (p_addrOe) else $error("address lines not driven");
   property p_ctlOe; ioOe[42:39] == 4'hF; endproperty
   a_ctlOe: assert property (p_ctlOe) else $error("control lines not driven");
   property p_release; !(ioOut[41] && !ioOut[42]) |-> ioOe[38:22] == 17'h00000; endproperty
   a_release: assert property (p_release) else $error("data lines held outside write");
   property p_start; $fell(memSel_n) && ioOut[39] |-> ##2 !ioOut[39]
      && ioOut[21:0] == $past(memAddr, 2) && ioOut[42] == $past(rdWr, 2); endproperty
   a_start: assert property (p_start) else $error("transfer not started");
   property p_strobeLen;
      $fell(ioOut[41]) |-> strobeCnt_q == (ioOut[42] ? RD_DATA_CYC : WR_DATA_CYC); endproperty
   a_strobeLen: assert property (p_strobeLen) else $error("data phase length wrong");
   property p_strobeIn; ioOut[41] |-> !ioOut[39]; endproperty
   a_strobeIn: assert property (p_strobeIn) else $error("data strobe outside transfer");
endmodule : pio_tape_checker
bind pio_tape_top pio_tape_checker #(.RD_DATA_CYC(RD_DATA_CYC), .WR_DATA_CYC(WR_DATA_CYC)) chk (
   .sys_clk, .rst, .ioSel_n, .memSel_n, .rdWr, .memAddr, .ipDataOe, .ack_n, .ioOut, .ioOe);
`default_nettype wire

// [pio_tape_model.sv]
/* Tape unit on the far side of the 48 lines.
   Data lines have pull-ups; the tape drives them only in a read strobe. */
`timescale 1ns/1ps
`default_nettype none
module pio_tape_model (
   // Device lines
   input  wire logic [47:0] ioOut,
   input  wire logic [47:0] ioOe,
   // Tape word and status lines
   input  wire logic [15:0] rdWord,
   input  wire logic [4:0]  stat,
   output logic      [47:0] ioIn
);
   // Even parity; a sinking driver beats the pull-up
   assign ioIn = {stat, ioOut[42:39],
                  (ioOut[41] && ioOut[42]) ? {^rdWord, rdWord} : ~ioOe[38:22],
                  ioOut[21:0]};
endmodule : pio_tape_model
`default_nettype wire

// [pio_tape_top_bench.sv]
/* Self-checking bench of pio_tape_top with the tape model on its lines.
   Short sequencer delays keep each transfer to a few cycles. */
`timescale 1ns/1ps
`default_nettype none
module pio_tape_top_bench;
   typedef struct {logic [5:0] a; logic [15:0] w; logic [15:0] e;} pio_row_t;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  spaceSel_n = 4'hF;
   logic        rdWr = 1'b1;
   logic [5:0]  ipAddr = 6'h00;
   logic [21:0] memAddr = 22'h000000;
   logic [15:0] ipDataIn = 16'h0000;
   logic [15:0] rdWord = 16'hBEEF;
   logic [4:0]  stat = 5'h00;
   logic [15:0] ipDataOut, q;
   logic        ipDataOe, ack_n, intReq0_n;
   logic [47:0] ioIn, ioOut, ioOe;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   pio_row_t    rows [8] = '{'{6'h00, 16'hA5C3, 16'hA5C3}, '{6'h02, 16'h1357, 16'h1357},
      '{6'h07, 16'h00C9, 16'h00C9}, '{6'h08, 16'hF0F0, 16'hF0F0}, '{6'h0B, 16'h2468, 16'h2468},
      '{6'h0C, 16'h0F0F, 16'h0F0F}, '{6'h13, 16'h9ABC, 16'h9ABC}, '{6'h17, 16'h5555, 16'h0000}};
   pio_tape_top #(.SETUP_CYC(2), .RD_DATA_CYC(4), .WR_DATA_CYC(8), .RECOVER_CYC(2),
      .ID_BYTE1(8'h3C)) uut (  // Arbitrary identity value
      .sys_clk, .rst, .ioSel_n(spaceSel_n[0]), .memSel_n(spaceSel_n[1]), .idSel_n(spaceSel_n[2]),
      .intSel_n(spaceSel_n[3]), .rdWr, .ipAddr, .memAddr, .ipDataIn, .ipDataOut, .ipDataOe,
      .ack_n, .intReq0_n, .ioIn, .ioOut, .ioOe);
   pio_tape_model tape (.ioOut, .ioOe, .rdWord, .stat, .ioIn);
   initial forever #2.5 sys_clk = ~sys_clk;
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Select is held until ack is sampled, then released for one idle edge
   task automatic acc(input int sp, input logic wr, input logic [5:0] a, input logic [15:0] d);
      int k;
      @(posedge sys_clk);
      spaceSel_n[sp] <= 1'b0;
      rdWr <= ~wr;
      ipAddr <= a;
      ipDataIn <= d;
      for (k = 0; k < 8 && ack_n !== 1'b0; k++) @(posedge sys_clk);
      chk(ack_n, 1'b0, "ack");
      q = ipDataOut;
      spaceSel_n <= 4'hF;
      @(posedge sys_clk);
   endtask : acc
   task automatic rdChk(input logic [5:0] a, input logic [15:0] e, input string w);
      acc(0, 1'b0, a, 16'h0000);
      chk(q, e, w);
   endtask : rdChk
   task automatic waitIdle;
      int k;
      for (k = 0; k < 40; k++)
      begin
         acc(0, 1'b0, 6'h0F, 16'h0000);
         if (q[0] === 1'b0) break;
      end
      chk(q[0], 1'b0, "busy");
   endtask : waitIdle
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         end_sim();
      end
   end
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk(ioOe[38:22], 17'h00000, "released");
      chk(ioOut[42:39], 4'hB, "idle strobes");
      rdChk(6'h04, 16'h0000, "mask reset");
      foreach (rows[i])
      begin
         acc(0, 1'b1, rows[i].a, rows[i].w);
         rdChk(rows[i].a, rows[i].e, "readback");
      end
      acc(3, 1'b0, 6'h00, 16'h0000);
      chk(q, 16'h00C9, "int vector");
      acc(2, 1'b0, 6'h01, 16'h0000);
      chk(q, 16'h003C, "id byte");
      memAddr <= 22'h2A5A5;
      acc(1, 1'b1, 6'h00, 16'h1234);
      chk(ioOut[21:0], 22'h2A5A5, "address");
      while (ioOut[41] !== 1'b1 && cyc < 19000) @(posedge sys_clk);
      chk(ioOe[38:22], 17'h0EDCB, "write data");
      acc(0, 1'b0, 6'h0F, 16'h0000);
      chk(q[0], 1'b1, "busy set");
      waitIdle();
      memAddr <= 22'h01357;
      acc(1, 1'b0, 6'h00, 16'h0000);
      chk(ioOut[42], 1'b1, "read dir");
      waitIdle();
      rdChk(6'h01, 16'hBEEF, "capture");
      acc(0, 1'b0, 6'h0F, 16'h0000);
      chk(q[1], 1'b0, "parity");
      rdChk(6'h14, 16'h1357, "raw0");
      rdChk(6'h16, 16'h05FF, "raw2");
      acc(0, 1'b1, 6'h06, 16'h1800);
      acc(0, 1'b1, 6'h0A, 16'h0800);
      acc(0, 1'b1, 6'h0E, 16'h1000);
      acc(0, 1'b1, 6'h03, 16'h0002);
      repeat (4) @(posedge sys_clk);
      chk(intReq0_n, 1'b0, "irq");
      rdChk(6'h12, 16'h1000, "inverted");
      rdChk(6'h12, 16'h1000, "level");
      stat <= 5'h01;
      repeat (2) @(posedge sys_clk);
      stat <= 5'h00;
      repeat (3) @(posedge sys_clk);
      rdChk(6'h12, 16'h1800, "pulse");
      stat <= 5'h01;
      repeat (4) @(posedge sys_clk);
      rdChk(6'h12, 16'h1800, "edge");
      rdChk(6'h12, 16'h1000, "no edge");
      acc(0, 1'b1, 6'h0E, 16'h0000);
      acc(0, 1'b0, 6'h12, 16'h0000);
      rdChk(6'h12, 16'h0000, "cleared");
      repeat (3) @(posedge sys_clk);
      chk(intReq0_n, 1'b1, "irq off");
      acc(0, 1'b1, 6'h03, 16'h0006);
      repeat (2) @(posedge sys_clk);
      chk(intReq0_n, 1'b0, "forced");
      acc(0, 1'b1, 6'h03, 16'h0004);
      repeat (2) @(posedge sys_clk);
      chk(intReq0_n, 1'b1, "force no enable");
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rdChk(6'h03, 16'h0000, "base reset");
      end_sim();
   end
endmodule : pio_tape_top_bench
`default_nettype wire
